/* File: design/fsr_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fsr_regs.svh"
// fault snapshot recorder: latches drive values on each fault outside the settle window
module fsr_top
(
	input wire logic core_clk, // 250 mhz system clock
	input wire logic rst_n, // async reset, active low
	input wire logic faultEvt, // one-cycle pulse, a new fault
	input wire logic [9:0] faultCode, // code of the new fault
	input wire logic [4:0] timeHour, // live time of day, hours
	input wire logic [5:0] timeMin, // live time of day, minutes
	input wire logic [15:0] liveCurrent, // output current, 0.1 a units
	input wire logic [15:0] liveDcLink, // dc link volts
	input wire logic [15:0] liveSpeed, // motor speed rpm
	input wire logic [15:0] liveSpeedRef, // speed reference rpm
	input wire logic [15:0] liveFreq, // output frequency, 0.1 hz units
	input wire logic [15:0] liveMotVolt, // motor volts
	input wire logic [7:0] digitalInputN, // live digital inputs, bit0 = input 1
	input wire logic [4:0] digitalOutputN, // live digital outputs, bit0 = output 1
	input wire logic [6:0] rdIdx, // parameter number to read
	input wire logic wrEn, // write attempt strobe
	input wire logic [6:0] wrIdx, // parameter number of the write
	output logic [15:0] rdData, // registered read value
	output logic wrRefused, // pulse, a write to a snapshot or history field was dropped
	output logic snapValid, // snapshot taken outside the reset window
	output logic [15:0] snapCurrent, // captured current
	output logic [15:0] snapDcLink, // captured dc link
	output logic [15:0] snapSpeed, // captured speed
	output logic [15:0] snapSpeedRef, // captured reference
	output logic [15:0] snapFreq, // captured frequency
	output logic [15:0] snapMotVolt, // captured motor voltage
	output logic [15:0] faultInputStates, // captured inputs word
	output logic [15:0] faultOutputStates, // captured outputs word
	output fsr_pkg::fsr_code_type lastFaultCode // newest history code
);

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	// clamp a raw value to its documented range
	function automatic logic [15:0] satWord(input logic [15:0] v, input logic [15:0] lim);
		satWord = (v > lim) ? lim : v;
	endfunction

	// is the index one of the snapshot or history parameters
	function automatic logic isOwnIdx(input logic [6:0] idx);
		isOwnIdx = (idx >= `FSR_IDX_HIST_BASE) && (idx <= `FSR_IDX_OUTSTATES);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// declarations
	fsr_pkg::fsr_state_type state_r; // capture sequencer
	fsr_pkg::fsr_state_type state_nxt; // its next value
	logic [1:0] settleCnt_r; // cycles since reset release
	logic capture; // load strobe for all snapshot fields
	logic [15:0] rdData_nxt; // read mux result
	logic [6:0] rel; // read index relative to history base
	logic [3:0] slot; // history slot addressed
	logic [15:0] hourSat; // clamped hour
	logic [15:0] minSat; // clamped minute
	logic [15:0] codeSat; // clamped code
	fsr_hist_if hist(); // link to the history store

	assign capture = faultEvt && (state_r != fsr_pkg::FSR_ST_SETTLE); // RULE_14
	assign hourSat = satWord({11'h000, timeHour}, `FSR_MAX_HOUR);
	assign minSat = satWord({10'h000, timeMin}, `FSR_MAX_MIN);
	assign codeSat = satWord({6'h00, faultCode}, `FSR_MAX_CODE);

	////////////////////////////////////////////////////////////////////////////////
	// history store, pushed on every fault including one during settling
	assign hist.push = faultEvt; // RULE_12
	assign hist.code = codeSat[9:0];
	assign hist.hour = hourSat[4:0]; // RULE_01
	assign hist.minute = minSat[5:0]; // RULE_01

	fsr_history uHistory
	(
		.core_clk(core_clk),
		.rst_n(rst_n),
		.hist(hist)
	);

	////////////////////////////////////////////////////////////////////////////////
	// settle counter: live values right after reset are not trusted
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			settleCnt_r <= 2'h0;
		else if (settleCnt_r != `FSR_SETTLE_CYC)
			settleCnt_r <= settleCnt_r + 2'h1; // RULE_13
	end

	////////////////////////////////////////////////////////////////////////////////
	// sequencer next state
	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			fsr_pkg::FSR_ST_SETTLE:
			begin
				// a fault here still goes into history, but not the snapshot
				if (settleCnt_r == `FSR_SETTLE_CYC)
					state_nxt = fsr_pkg::FSR_ST_ARMED; // RULE_13
			end
			fsr_pkg::FSR_ST_ARMED:
			begin
				if (faultEvt)
					state_nxt = fsr_pkg::FSR_ST_LOAD;
			end
			fsr_pkg::FSR_ST_LOAD:
			begin
				// back-to-back faults stay here and keep loading
				if (!faultEvt)
					state_nxt = fsr_pkg::FSR_ST_ARMED;
			end
			default:
				state_nxt = fsr_pkg::FSR_ST_SETTLE;
		endcase
	end

	// sequencer register
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			state_r <= fsr_pkg::FSR_ST_SETTLE;
		else
			state_r <= state_nxt;
	end

	////////////////////////////////////////////////////////////////////////////////
	// validity: a fault inside the settle window marks the snapshot invalid
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			snapValid <= 1'b0;
		else if (faultEvt)
			snapValid <= (state_r != fsr_pkg::FSR_ST_SETTLE); // RULE_13
	end

	////////////////////////////////////////////////////////////////////////////////
	// analog snapshot: all fields on the same edge so they never mix faults
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			snapCurrent <= `FSR_RST_WORD;
			snapDcLink <= `FSR_RST_WORD;
			snapSpeed <= `FSR_RST_WORD;
			snapSpeedRef <= `FSR_RST_WORD;
			snapFreq <= `FSR_RST_WORD;
			snapMotVolt <= `FSR_RST_WORD;
		end
		else if (capture) // RULE_14
		begin
			snapCurrent <= satWord(liveCurrent, `FSR_MAX_CURRENT); // RULE_02
			snapDcLink <= satWord(liveDcLink, `FSR_MAX_VOLT); // RULE_03
			snapSpeed <= satWord(liveSpeed, `FSR_MAX_RPM); // RULE_04
			snapSpeedRef <= satWord(liveSpeedRef, `FSR_MAX_RPM); // RULE_05
			snapFreq <= satWord(liveFreq, `FSR_MAX_FREQ); // RULE_06
			snapMotVolt <= satWord(liveMotVolt, `FSR_MAX_VOLT); // RULE_07
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// packed pin states; unused upper bits are forced low by construction
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			faultInputStates <= `FSR_RST_WORD;
			faultOutputStates <= `FSR_RST_WORD;
		end
		else if (capture) // RULE_14
		begin
			faultInputStates <= {8'h00, digitalInputN}; // RULE_08 RULE_09 RULE_11
			faultOutputStates <= {11'h000, digitalOutputN}; // RULE_10 RULE_11
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// newest code mirrored to a port register
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			lastFaultCode <= 10'h000;
		else if (faultEvt)
			lastFaultCode <= codeSat[9:0]; // RULE_12
	end

	////////////////////////////////////////////////////////////////////////////////
	// read mux: history slots every four numbers, then the snapshot fields
	always_comb
	begin
		rel = rdIdx - `FSR_IDX_HIST_BASE;
		slot = rel[5:2];
		rdData_nxt = 16'h0000;
		if (rdIdx == `FSR_IDX_CURRENT)
			rdData_nxt = snapCurrent;
		else if (rdIdx == `FSR_IDX_DCLINK)
			rdData_nxt = snapDcLink;
		else if (rdIdx == `FSR_IDX_SPEED)
			rdData_nxt = snapSpeed;
		else if (rdIdx == `FSR_IDX_SPEEDREF)
			rdData_nxt = snapSpeedRef;
		else if (rdIdx == `FSR_IDX_FREQ)
			rdData_nxt = snapFreq;
		else if (rdIdx == `FSR_IDX_MOTVOLT)
			rdData_nxt = snapMotVolt;
		else if (rdIdx == `FSR_IDX_INSTATES)
			rdData_nxt = faultInputStates; // RULE_11
		else if (rdIdx == `FSR_IDX_OUTSTATES)
			rdData_nxt = faultOutputStates; // RULE_11
		else if (isOwnIdx(rdIdx) && (slot < 4'(`FSR_HIST_DEPTH)))
		begin
			// date fields have no source here and read zero
			if (rel[1:0] == 2'b00)
				rdData_nxt = {6'h00, hist.codes[slot]};
			else if (rel[1:0] == 2'(`FSR_IDX_TIME_OFS))
				rdData_nxt = {3'h0, hist.hours[slot], 2'h0, hist.minutes[slot]}; // RULE_01
		end
	end

	// registered read data; unmapped numbers read zero
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			rdData <= `FSR_RST_WORD;
		else
			rdData <= rdData_nxt;
	end

	////////////////////////////////////////////////////////////////////////////////
	// all recorder fields are read-only: a write only raises the refused pulse
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			wrRefused <= 1'b0;
		else
			wrRefused <= wrEn && isOwnIdx(wrIdx); // RULE_14
	end

endmodule
`default_nettype wire

/* File: design/fsr_regs.svh */
// How it works
// RULE_01: store hour and minute per recorded fault
// RULE_02: capture output current, tenths, max 4000.0 A
// RULE_03: capture dc link volts, 0 to 2000
// RULE_04: capture motor speed rpm, 0 to 18000
// RULE_05: capture speed reference rpm, 0 to 18000
// RULE_06: capture output frequency, tenths, max 300.0 Hz
// RULE_07: capture motor volts, 0 to 2000
// RULE_08: eight inputs packed bits 0-7, input1 bit0
// RULE_09: input field bits above seven read zero
// RULE_10: five outputs bits 0-4, higher bits zero
// RULE_11: packed states read as four-digit hex word
// RULE_12: new fault shifts ten-deep code history
// RULE_13: fault at reset may leave snapshot invalid
// RULE_14: fields load together, writes are ignored
`ifndef FSR_REGS_SVH
`define FSR_REGS_SVH

// history depth
`define FSR_HIST_DEPTH 10
// parameter numbers of the history slots: code, day/month, year, time
`define FSR_IDX_HIST_BASE 7'd50
`define FSR_IDX_HIST_STEP 7'd4
`define FSR_IDX_TIME_OFS 7'd3
// parameter numbers of the snapshot fields
`define FSR_IDX_CURRENT 7'd90
`define FSR_IDX_DCLINK 7'd91
`define FSR_IDX_SPEED 7'd92
`define FSR_IDX_SPEEDREF 7'd93
`define FSR_IDX_FREQ 7'd94
`define FSR_IDX_MOTVOLT 7'd95
`define FSR_IDX_INSTATES 7'd96
`define FSR_IDX_OUTSTATES 7'd97
// range limits in raw units
`define FSR_MAX_HOUR 16'h0017
`define FSR_MAX_MIN 16'h003b
`define FSR_MAX_CURRENT 16'h9c40
`define FSR_MAX_VOLT 16'h07d0
`define FSR_MAX_RPM 16'h4650
`define FSR_MAX_FREQ 16'h0bb8
`define FSR_MAX_CODE 16'h03e7
// field widths of the packed state words
`define FSR_NUM_DIN 8
`define FSR_NUM_DOUT 5
// reset values
`define FSR_RST_WORD 16'h0000
// settle count end value; captures count as valid from the fourth edge after reset release
`define FSR_SETTLE_CYC 2'h2

`endif

/* File: design/fsr_pkg.sv */
`default_nettype none
package fsr_pkg;

	typedef logic [15:0] fsr_word_type; // one parameter value
	typedef logic [9:0] fsr_code_type; // fault code 0..999
	typedef logic [4:0] fsr_hour_type; // 0..23
	typedef logic [5:0] fsr_min_type; // 0..59
	typedef fsr_code_type [9:0] fsr_code_arr_type; // history codes, slot 0 newest
	typedef fsr_hour_type [9:0] fsr_hour_arr_type; // history hours
	typedef fsr_min_type [9:0] fsr_min_arr_type; // history minutes

	// capture sequencer, gray along settle -> armed -> load
	typedef enum logic [1:0]
	{
		FSR_ST_SETTLE = 2'b00,
		FSR_ST_ARMED = 2'b01,
		FSR_ST_LOAD = 2'b11
	} fsr_state_type;

endpackage
`default_nettype wire

/* File: design/fsr_hist_if.sv */
`timescale 1ns/1ps
`default_nettype none
// carries the push request and the history contents between top and history
interface fsr_hist_if;
	logic push; // one-cycle push of a new fault
	fsr_pkg::fsr_code_type code; // new fault code
	fsr_pkg::fsr_hour_type hour; // new fault hour
	fsr_pkg::fsr_min_type minute; // new fault minute
	fsr_pkg::fsr_code_arr_type codes; // stored codes
	fsr_pkg::fsr_hour_arr_type hours; // stored hours
	fsr_pkg::fsr_min_arr_type minutes; // stored minutes

	modport ctrl (output push, output code, output hour, output minute, input codes, input hours, input minutes);
	modport store (input push, input code, input hour, input minute, output codes, output hours, output minutes);
endinterface
`default_nettype wire

/* File: design/fsr_history.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fsr_regs.svh"
// ten-deep fault history, slot 0 holds the newest fault
module fsr_history
(
	input wire logic core_clk, // system clock
	input wire logic rst_n, // async reset, active low
	fsr_hist_if.store hist // push in, contents out
);

	////////////////////////////////////////////////////////////////////////////////
	// code shift: oldest slot falls off the end
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			hist.codes <= '0;
		else if (hist.push)
		begin
			for (int i = `FSR_HIST_DEPTH - 1; i > 0; i--)
				hist.codes[i] <= hist.codes[i-1]; // RULE_12
			hist.codes[0] <= hist.code; // RULE_12
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// time of day moves with its code so each slot stays consistent
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hist.hours <= '0;
			hist.minutes <= '0;
		end
		else if (hist.push)
		begin
			for (int i = `FSR_HIST_DEPTH - 1; i > 0; i--)
			begin
				hist.hours[i] <= hist.hours[i-1]; // RULE_01
				hist.minutes[i] <= hist.minutes[i-1]; // RULE_01
			end
			hist.hours[0] <= hist.hour; // RULE_01
			hist.minutes[0] <= hist.minute; // RULE_01
		end
	end

endmodule
`default_nettype wire

/* File: test/fsr_top_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// watches the recorder ports; all checks on the core clock
module fsr_top_chk
(
	input wire logic core_clk, // clock
	input wire logic rst_n, // reset, active low
	input wire logic faultEvt, // fault pulse
	input wire logic [9:0] faultCode, // fault code
	input wire logic [15:0] liveCurrent, // live current
	input wire logic [15:0] liveDcLink, // live dc link
	input wire logic [15:0] liveFreq, // live frequency
	input wire logic [7:0] digitalInputN, // live inputs
	input wire logic [4:0] digitalOutputN, // live outputs
	input wire logic [6:0] rdIdx, // read number
	input wire logic wrEn, // write strobe
	input wire logic [6:0] wrIdx, // write number
	input wire logic [15:0] rdData, // read value
	input wire logic wrRefused, // write dropped
	input wire logic snapValid, // snapshot valid
	input wire logic [15:0] snapCurrent, // held current
	input wire logic [15:0] snapDcLink, // held dc link
	input wire logic [15:0] snapFreq, // held frequency
	input wire logic [15:0] faultInputStates, // held inputs
	input wire logic [15:0] faultOutputStates, // held outputs
	input wire logic [9:0] lastFaultCode // newest code
);
	////////////////////////////////////////
	// reset masks every check; a fault in settle may leave data stale
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// captures are only judged when the design claims them valid
	cur_capture_a:
	assert property (faultEvt |=> !snapValid || snapCurrent == ($past(liveCurrent) > 16'h9c40 ? 16'h9c40 : $past(liveCurrent)))
		else $error("current snapshot wrong");
	dc_capture_a:
	assert property (faultEvt |=> !snapValid || snapDcLink == ($past(liveDcLink) > 16'h07d0 ? 16'h07d0 : $past(liveDcLink)))
		else $error("dc link snapshot wrong");
	freq_capture_a:
	assert property (faultEvt |=> !snapValid || snapFreq == ($past(liveFreq) > 16'h0bb8 ? 16'h0bb8 : $past(liveFreq)))
		else $error("frequency snapshot wrong");
	in_pack_a:
	assert property (faultEvt |=> !snapValid || faultInputStates == {8'h00, $past(digitalInputN)})
		else $error("input word wrong");
	out_pack_a:
	assert property (faultEvt |=> !snapValid || faultOutputStates == {11'h000, $past(digitalOutputN)})
		else $error("output word wrong");
	snap_hold_a:
	assert property (!faultEvt |=> $stable(snapCurrent) && $stable(faultInputStates) && $stable(snapValid))
		else $error("snapshot moved without fault");
	write_refuse_a:
	assert property (1'b1 |=> wrRefused == $past(wrEn && wrIdx >= 7'd50 && wrIdx <= 7'd97))
		else $error("write refusal wrong");
	code_push_a:
	assert property (faultEvt |=> lastFaultCode == ($past(faultCode) > 10'd999 ? 10'd999 : $past(faultCode)))
		else $error("newest code wrong");
	in_read_a:
	assert property (rdIdx == 7'd96 |=> rdData == $past(faultInputStates))
		else $error("input word read wrong");
endmodule
bind fsr_top fsr_top_chk u_fsr_top_chk (.core_clk, .rst_n, .faultEvt, .faultCode, .liveCurrent, .liveDcLink,
	.liveFreq, .digitalInputN, .digitalOutputN, .rdIdx, .wrEn, .wrIdx, .rdData, .wrRefused, .snapValid,
	.snapCurrent, .snapDcLink, .snapFreq, .faultInputStates, .faultOutputStates, .lastFaultCode);
`default_nettype wire

/* File: test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the fault snapshot recorder
module tb;
	logic core_clk, rst_n, faultEvt, wrEn, wrRefused, snapValid; // clock, reset, strobes, flags
	logic [9:0] faultCode; // fault code driven
	logic [4:0] timeHour, digitalOutputN; // hour, outputs
	logic [5:0] timeMin; // minute
	logic [7:0] digitalInputN; // inputs
	logic [6:0] rdIdx, wrIdx; // parameter numbers
	logic [15:0] liveCurrent, liveDcLink, liveSpeed, liveSpeedRef, liveFreq, liveMotVolt; // live values
	logic [15:0] rdData, snapCurrent, snapDcLink, snapSpeed, snapSpeedRef, snapFreq, snapMotVolt; // results
	logic [15:0] faultInputStates, faultOutputStates; // state words
	fsr_pkg::fsr_code_type lastFaultCode; // newest code
	int err_count, checked; // tallies
	fsr_top u_fsr_top (.core_clk, .rst_n, .faultEvt, .faultCode, .timeHour, .timeMin, .liveCurrent, .liveDcLink,
		.liveSpeed, .liveSpeedRef, .liveFreq, .liveMotVolt, .digitalInputN, .digitalOutputN, .rdIdx, .wrEn, .wrIdx,
		.rdData, .wrRefused, .snapValid, .snapCurrent, .snapDcLink, .snapSpeed, .snapSpeedRef, .snapFreq,
		.snapMotVolt, .faultInputStates, .faultOutputStates, .lastFaultCode);
	////////////////////////////////////////
	// free-running 250 mhz clock
	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	// hang guard, far beyond the 63 cycles the run needs
	initial
	begin
		#100000;
		err_count++;
		finish_test();
	end
	////////////////////////////////////////
	// one compare; case inequality so unknowns fail
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// read is registered: value shows one cycle after the number
	task automatic rd(input logic [6:0] idx, input logic [15:0] exp);
		rdIdx = idx;
		@(negedge core_clk);
		chk("rdData", exp, rdData);
	endtask
	// one fault pulse with all live values; results land one edge later
	task automatic fault(input logic [15:0] c, d, s, r, f, m, input logic [7:0] di, input logic [4:0] dq,
		input logic [9:0] fc);
		liveCurrent = c;
		liveDcLink = d;
		liveSpeed = s;
		liveSpeedRef = r;
		liveFreq = f;
		liveMotVolt = m;
		digitalInputN = di;
		digitalOutputN = dq;
		faultCode = fc;
		faultEvt = 1'b1;
		@(negedge core_clk);
		faultEvt = 1'b0;
	endtask
	////////////////////////////////////////
	// in-range values, packed words as hex codes
	task automatic s_capture;
		timeHour = 5'd13;
		timeMin = 6'd45;
		fault(16'h1234, 16'h07d0, 16'h4650, 16'h0001, 16'h0bb8, 16'h0000, 8'ha5, 5'h1c, 10'd7);
		chk("snapCurrent", 16'h1234, snapCurrent);
		chk("snapDcLink", 16'h07d0, snapDcLink);
		chk("snapSpeed", 16'h4650, snapSpeed);
		chk("snapSpeedRef", 16'h0001, snapSpeedRef);
		chk("snapFreq", 16'h0bb8, snapFreq);
		chk("snapMotVolt", 16'h0000, snapMotVolt);
		chk("snapValid", 16'h0001, {15'h0000, snapValid});
		rd(7'd96, 16'h00a5);
		rd(7'd97, 16'h001c);
		rd(7'd53, {3'b000, 5'd13, 2'b00, 6'd45});
		rd(7'd50, 16'd7);
		rd(7'd51, 16'h0000);
		rd(7'd90, 16'h1234);
		rd(7'd91, 16'h07d0);
		rd(7'd92, 16'h4650);
		rd(7'd93, 16'h0001);
		rd(7'd94, 16'h0bb8);
		rd(7'd95, 16'h0000);
	endtask
	// values past the top of each range read back at the top
	task automatic s_clamp;
		timeHour = 5'd31;
		timeMin = 6'd63;
		fault(16'h9c41, 16'h07d1, 16'h4651, 16'hffff, 16'h0bb9, 16'h07d1, 8'hff, 5'h1f, 10'h3ff);
		chk("snapCurrent", 16'h9c40, snapCurrent);
		chk("snapSpeedRef", 16'h4650, snapSpeedRef);
		chk("snapMotVolt", 16'h07d0, snapMotVolt);
		chk("snapDcLink", 16'h07d0, snapDcLink);
		chk("snapSpeed", 16'h4650, snapSpeed);
		chk("snapFreq", 16'h0bb8, snapFreq);
		chk("faultInputStates", 16'h00ff, faultInputStates);
		chk("faultOutputStates", 16'h001f, faultOutputStates);
		chk("lastFaultCode", 16'd999, {6'h00, lastFaultCode});
		rd(7'd53, {3'b000, 5'd23, 2'b00, 6'd59});
	endtask
	// writes to numbers 50 to 97 are dropped and flagged, others not; unmapped numbers read zero
	task automatic s_write;
		wrEn = 1'b1;
		wrIdx = 7'd90;
		@(negedge core_clk);
		chk("wrRefused", 16'h0001, {15'h0000, wrRefused});
		wrIdx = 7'd50;
		@(negedge core_clk);
		chk("wrRefused", 16'h0001, {15'h0000, wrRefused});
		wrIdx = 7'd98;
		@(negedge core_clk);
		chk("wrRefused", 16'h0000, {15'h0000, wrRefused});
		wrIdx = 7'd10;
		@(negedge core_clk);
		chk("wrRefused", 16'h0000, {15'h0000, wrRefused});
		wrEn = 1'b0;
		chk("snapCurrent", 16'h9c40, snapCurrent);
		rd(7'd20, 16'h0000);
	endtask
	// eleven back-to-back faults: oldest falls out of slot nine
	task automatic s_history;
		for (int k = 1; k <= 11; k++)
		begin
			faultCode = k[9:0];
			faultEvt = 1'b1;
			@(negedge core_clk);
		end
		faultEvt = 1'b0;
		for (int s = 0; s < 10; s++)
			rd(7'd50 + 7'(4 * s), 16'(11 - s));
	endtask
	// fault on the first edge after a mid-run reset is not loaded
	task automatic s_reset;
		rst_n = 1'b0;
		@(negedge core_clk);
		rst_n = 1'b1;
		fault(16'h0555, 16'h0001, 16'h0001, 16'h0001, 16'h0001, 16'h0001, 8'h01, 5'h01, 10'd321);
		chk("snapValid", 16'h0000, {15'h0000, snapValid});
		chk("snapCurrent", 16'h0000, snapCurrent);
		chk("lastFaultCode", 16'd321, {6'h00, lastFaultCode});
		repeat (4) @(negedge core_clk);
		fault(16'h0666, 16'h0001, 16'h0001, 16'h0001, 16'h0001, 16'h0001, 8'h01, 5'h01, 10'd322);
		chk("snapCurrent", 16'h0666, snapCurrent);
		chk("snapValid", 16'h0001, {15'h0000, snapValid});
	endtask
	////////////////////////////////////////
	// verdict and end of run, shared with the hang guard
	task automatic finish_test;
		if (err_count == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// main sequence, inputs change on falling edges only
	initial
	begin
		{rst_n, faultEvt, wrEn, faultCode, timeHour, timeMin, digitalInputN, digitalOutputN} = '0;
		{liveCurrent, liveDcLink, liveSpeed, liveSpeedRef, liveFreq, liveMotVolt, rdIdx, wrIdx} = '0;
		err_count = 0;
		checked = 0;
		repeat (12) @(negedge core_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge core_clk);
		s_capture();
		s_clamp();
		s_write();
		s_history();
		s_reset();
		finish_test();
	end
endmodule
`default_nettype wire
